// [common/usbied_pkg.sv]
/*
 * Constants, types and helper functions for the interface and endpoint
 * descriptor streamer: descriptor layouts, field offsets, default endpoint
 * table and the state encoding.
 * Assumes a single clock domain and byte-wide descriptor traffic.
 */
package usbied_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Descriptor header codes
    localparam logic [7:0] USBIED_IF_LEN       = 8'h09;
    localparam logic [7:0] USBIED_IF_TYPE      = 8'h04;
    localparam logic [7:0] USBIED_EP_LEN       = 8'h07;
    localparam logic [7:0] USBIED_EP_TYPE      = 8'h05;
    localparam logic [7:0] USBIED_CLASS_NONE   = 8'h00;
    localparam logic [7:0] USBIED_CLASS_VENDOR = 8'hFF;
    localparam logic [7:0] USBIED_PROTO_VENDOR = 8'hFF;
    localparam logic [7:0] USBIED_ZERO_BYTE    = 8'h00;

    // Interface descriptor byte offsets
    localparam logic [3:0] USBIED_IF_OFS_LEN   = 4'h0;
    localparam logic [3:0] USBIED_IF_OFS_TYPE  = 4'h1;
    localparam logic [3:0] USBIED_IF_OFS_NUM   = 4'h2;
    localparam logic [3:0] USBIED_IF_OFS_ALT   = 4'h3;
    localparam logic [3:0] USBIED_IF_OFS_NEP   = 4'h4;
    localparam logic [3:0] USBIED_IF_OFS_CLASS = 4'h5;
    localparam logic [3:0] USBIED_IF_OFS_SUB   = 4'h6;
    localparam logic [3:0] USBIED_IF_OFS_PROTO = 4'h7;
    localparam logic [3:0] USBIED_IF_OFS_STR   = 4'h8;

    // Endpoint descriptor byte offsets
    localparam logic [3:0] USBIED_EP_OFS_LEN   = 4'h0;
    localparam logic [3:0] USBIED_EP_OFS_TYPE  = 4'h1;
    localparam logic [3:0] USBIED_EP_OFS_ADDR  = 4'h2;
    localparam logic [3:0] USBIED_EP_OFS_ATTR  = 4'h3;
    localparam logic [3:0] USBIED_EP_OFS_PKTL  = 4'h4;
    localparam logic [3:0] USBIED_EP_OFS_PKTH  = 4'h5;
    localparam logic [3:0] USBIED_EP_OFS_IVL   = 4'h6;

    localparam int         USBIED_NUM_SLOTS    = 4;
    localparam logic [3:0] USBIED_IDX_ZERO     = 4'h0;
    localparam logic [3:0] USBIED_IDX_ONE      = 4'h1;
    localparam logic [2:0] USBIED_SLOT_ONE     = 3'h1;

    ////////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [1:0] {
        USBIED_XFER_CTRL = 2'b00,
        USBIED_XFER_ISO  = 2'b01,
        USBIED_XFER_BULK = 2'b10,
        USBIED_XFER_INTR = 2'b11
    } usbied_xfer_t;

    typedef enum logic [1:0] {
        USBIED_REQ_CONFIG = 2'b00,
        USBIED_REQ_IFACE  = 2'b01,
        USBIED_REQ_EP     = 2'b10,
        USBIED_REQ_OTHER  = 2'b11
    } usbied_req_t;

    typedef struct packed {
        logic         dir_in;
        logic [3:0]   num;
        usbied_xfer_t xfer;
        logic [15:0]  max_pkt;
        logic [7:0]   interval;
    } usbied_ep_t;

    typedef struct packed {
        logic [7:0] number;
        logic [7:0] alt;
        logic [7:0] cls;
        logic [7:0] sub;
        logic [7:0] proto;
        logic [7:0] str_idx;
    } usbied_if_cfg_t;

    typedef enum logic [2:0] {
        USBIED_ST_IDLE  = 3'b000,
        USBIED_ST_IFACE = 3'b001,
        USBIED_ST_SEEK  = 3'b010,
        USBIED_ST_WAIT  = 3'b011,
        USBIED_ST_SEND  = 3'b100
    } usbied_state_t;

    // Default endpoint table: bulk pair one, interrupt-in / bulk-out pair two [RULE14] [RULE15]
    localparam usbied_ep_t USBIED_EP_DEFAULTS [USBIED_NUM_SLOTS] = '{
        '{1'b1, 4'h1, USBIED_XFER_BULK, 16'h0010, 8'h00},
        '{1'b0, 4'h1, USBIED_XFER_BULK, 16'h0010, 8'h00},
        '{1'b1, 4'h2, USBIED_XFER_INTR, 16'h0008, 8'h64},
        '{1'b0, 4'h2, USBIED_XFER_BULK, 16'h0008, 8'h00}
    };

    ////////////////////////////////////////////////////////////////////////////
    // Helpers
    // First enabled slot at or above start: {found, slot}
    function automatic logic [2:0] usbied_find(input logic [3:0] mask,
                                               input logic [2:0] start);
        logic [2:0] r;
        r = 3'h0;
        for (int i = USBIED_NUM_SLOTS - 1; i >= 0; i--) begin
            if (mask[i] && (3'(i) >= start)) begin
                r = {1'b1, 2'(i)};
            end
        end
        return r;
    endfunction : usbied_find

    // Count of enabled endpoint slots
    function automatic logic [7:0] usbied_count(input logic [3:0] mask);
        logic [7:0] n;
        n = 8'h00;
        for (int i = 0; i < USBIED_NUM_SLOTS; i++) begin
            n = n + {7'h00, mask[i]};
        end
        return n;
    endfunction : usbied_count

endpackage : usbied_pkg

// [core/usbied_epenc.sv]
/*
 * Turns one endpoint table entry and a byte index into the byte of the
 * seven-byte endpoint descriptor that sits at that index.
 * Assumes the index stays within the endpoint descriptor length.
 */
`timescale 1ns/1ps
module usbied_epenc
    import usbied_pkg::*;
(
    input  usbied_ep_t       ep,
    input  wire logic [3:0]  idx,
    output logic      [7:0]  byte_out
);

    logic [7:0] addr_byte;
    logic [7:0] attr_byte;

    ////////////////////////////////////////////////////////////////////////////
    // Address: direction on top, three zero bits, endpoint number low
    assign addr_byte = {ep.dir_in, 3'b000, ep.num};   // [RULE16]
    // Attributes: transfer type low, reserved bits held at zero
    assign attr_byte = {6'b000000, ep.xfer};          // [RULE17]

    // Byte select; packet size goes out low byte first
    assign byte_out =
        (idx == USBIED_EP_OFS_LEN)  ? USBIED_EP_LEN      :
        (idx == USBIED_EP_OFS_TYPE) ? USBIED_EP_TYPE     :
        (idx == USBIED_EP_OFS_ADDR) ? addr_byte          :
        (idx == USBIED_EP_OFS_ATTR) ? attr_byte          :
        (idx == USBIED_EP_OFS_PKTL) ? ep.max_pkt[7:0]    :   // [RULE18]
        (idx == USBIED_EP_OFS_PKTH) ? ep.max_pkt[15:8]   :
        (idx == USBIED_EP_OFS_IVL)  ? ep.interval        :
                                      USBIED_ZERO_BYTE;

endmodule : usbied_epenc

// [core/usbied_rom.sv]
/*
 * Small read-only table of the default endpoint descriptors, one entry per
 * endpoint slot, with registered read data.
 * Assumes the reader waits one clock after presenting the slot address.
 */
`timescale 1ns/1ps
module usbied_rom
    import usbied_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [1:0] rd_addr,
    output usbied_ep_t      rd_data
);

    usbied_ep_t rd_data_q;

    ////////////////////////////////////////////////////////////////////////////
    // Registered read, one clock of latency
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rd_data_q <= '0;
        end else begin
            rd_data_q <= USBIED_EP_DEFAULTS[rd_addr];
        end
    end

    assign rd_data = rd_data_q;

endmodule : usbied_rom

// [core/usbied_top.sv]
/*
 * Descriptor streamer that supplies the interface descriptor and the
 * endpoint descriptors which follow the configuration header in the
 * configuration descriptor answer. Bytes leave one at a time over a
 * valid/ready pair with a last marker.
 * Assumes the enumeration logic sends the configuration header itself and
 * then requests this segment; the segment length is offered so that the
 * header can fold it into its total length field.
 */
`timescale 1ns/1ps

// Notes on behaviour
// [RULE1] Interface descriptor leaves only inside a configuration answer, standalone asks stall.
// [RULE2] Endpoint count reported excludes the default control endpoint zero.
// [RULE3] Interface byte 0 holds its length, nine.
// [RULE4] Interface byte 1 holds the interface descriptor type, four.
// [RULE5] Interface byte 2 holds the zero-based interface index, default zero.
// [RULE6] Interface byte 3 holds the alternate setting, default zero.
// [RULE7] Interface byte 4 holds endpoints used, default four; zero means endpoint zero only.
// [RULE8] Class byte 5 defaults zero; 0xFF means vendor class; others reserved.
// [RULE9] Subclass byte 6 is zero whenever class is zero.
// [RULE10] Protocol byte 7 defaults zero; 0xFF means vendor protocol.
// [RULE11] Interface byte 8 holds the string index, default zero.
// [RULE12] One endpoint descriptor goes out for every endpoint in use.
// [RULE13] Endpoint descriptors leave only inside a configuration answer.
// [RULE14] First pair defaults: bulk in and out, packet sixteen, interval zero.
// [RULE15] Second pair: interrupt in, packet eight, interval 0x64; bulk out, packet eight.
// [RULE16] Address byte: number in bits 3..0, zeros 6..4, bit 7 set for inbound.
// [RULE17] Attribute low bits: control, isochronous, bulk, interrupt; other bits zero.
// [RULE18] Interface follows header, endpoints follow in order, multi-byte fields low first.
module usbied_top
    import usbied_pkg::*;
(
    input  wire logic        MCLK,
    input  wire logic        NRST,
    input  wire logic        REQ_VALID,
    input  usbied_req_t      REQ_KIND,
    output logic             REQ_READY,
    output logic             REQ_STALL,
    input  usbied_if_cfg_t   IF_CFG,
    input  wire logic [3:0]  EP_ENABLE,
    output logic      [15:0] SEG_LEN,
    output logic             SEG_BUSY,
    output logic             TX_VALID,
    output logic      [7:0]  TX_DATA,
    output logic             TX_LAST,
    input  wire logic        TX_READY
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    usbied_state_t   state_q,  state_d;
    logic [3:0]      idx_q,    idx_d;
    logic [1:0]      slot_q,   slot_d;
    logic [3:0]      mask_q,   mask_d;
    usbied_if_cfg_t  cfg_q,    cfg_d;
    usbied_ep_t      ep_q,     ep_d;
    logic            valid_q,  valid_d;
    logic [7:0]      data_q,   data_d;
    logic            last_q,   last_d;
    logic            stall_q,  stall_d;
    logic [15:0]     seg_len_q;

    logic            req_take;
    logic            req_cfg;
    logic            adv;
    logic [7:0]      num_eps;
    logic [7:0]      if_sub;
    logic [7:0]      if_byte;
    logic [7:0]      ep_byte;
    logic [2:0]      seek_hit;
    logic [2:0]      next_hit;
    logic [2:0]      slot_next;
    logic            if_end;
    logic            ep_end;
    usbied_ep_t      rom_data;

    ////////////////////////////////////////////////////////////////////////////
    // Request decode; only a configuration answer starts the stream
    assign REQ_READY = (state_q == USBIED_ST_IDLE);
    assign req_take  = REQ_VALID && REQ_READY;
    assign req_cfg   = (REQ_KIND == USBIED_REQ_CONFIG);       // [RULE1] [RULE13]

    // Output stage may take a new byte when empty or being drained
    assign adv = !valid_q || TX_READY;

    ////////////////////////////////////////////////////////////////////////////
    // Interface descriptor fields
    // Count comes from the enabled slots only, endpoint zero never counted
    assign num_eps = usbied_count(mask_q);                    // [RULE2] [RULE7]
    // Class zero forces subclass zero; reserved codes pass through untouched
    assign if_sub  = (cfg_q.cls == USBIED_CLASS_NONE) ? USBIED_ZERO_BYTE
                                                      : cfg_q.sub;   // [RULE9]

    assign if_byte =
        (idx_q == USBIED_IF_OFS_LEN)   ? USBIED_IF_LEN  :     // [RULE3]
        (idx_q == USBIED_IF_OFS_TYPE)  ? USBIED_IF_TYPE :     // [RULE4]
        (idx_q == USBIED_IF_OFS_NUM)   ? cfg_q.number   :     // [RULE5]
        (idx_q == USBIED_IF_OFS_ALT)   ? cfg_q.alt      :     // [RULE6]
        (idx_q == USBIED_IF_OFS_NEP)   ? num_eps        :     // [RULE7]
        (idx_q == USBIED_IF_OFS_CLASS) ? cfg_q.cls      :     // [RULE8]
        (idx_q == USBIED_IF_OFS_SUB)   ? if_sub         :     // [RULE9]
        (idx_q == USBIED_IF_OFS_PROTO) ? cfg_q.proto    :     // [RULE10]
        (idx_q == USBIED_IF_OFS_STR)   ? cfg_q.str_idx  :     // [RULE11]
                                         USBIED_ZERO_BYTE;

    ////////////////////////////////////////////////////////////////////////////
    // Endpoint slot search
    // Current slot in SEEK, and the slot after it for the last marker
    assign slot_next = {1'b0, slot_q} + USBIED_SLOT_ONE;
    assign seek_hit  = usbied_find(mask_q, {1'b0, slot_q});   // [RULE12]
    assign next_hit  = usbied_find(mask_q, slot_next);

    assign if_end = (idx_q == USBIED_IF_OFS_STR);
    assign ep_end = (idx_q == USBIED_EP_OFS_IVL);

    ////////////////////////////////////////////////////////////////////////////
    // Default endpoint table and byte encoder
    usbied_rom u_rom (
        .clk     (MCLK),
        .rst_n   (NRST),
        .rd_addr (seek_hit[1:0]),
        .rd_data (rom_data)                                   // [RULE14] [RULE15]
    );

    usbied_epenc u_epenc (
        .ep       (ep_q),
        .idx      (idx_q),
        .byte_out (ep_byte)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer: interface first, then enabled endpoints in slot order
    always_comb begin
        state_d = state_q;
        idx_d   = idx_q;
        slot_d  = slot_q;
        mask_d  = mask_q;
        cfg_d   = cfg_q;
        ep_d    = ep_q;
        valid_d = valid_q && !TX_READY;
        data_d  = data_q;
        last_d  = last_q;
        stall_d = 1'b0;
        unique case (state_q)
            USBIED_ST_IDLE: begin
                if (req_take && req_cfg) begin
                    // Settings are caught here so a change mid-stream is harmless
                    cfg_d   = IF_CFG;
                    mask_d  = EP_ENABLE;
                    idx_d   = USBIED_IDX_ZERO;
                    slot_d  = 2'b00;
                    state_d = USBIED_ST_IFACE;                // [RULE18]
                end else if (req_take) begin
                    stall_d = 1'b1;                           // [RULE1] [RULE13]
                end
            end
            USBIED_ST_IFACE: begin
                if (adv) begin
                    valid_d = 1'b1;
                    data_d  = if_byte;
                    last_d  = if_end && (mask_q == 4'h0);
                    idx_d   = idx_q + USBIED_IDX_ONE;
                    if (if_end) begin
                        idx_d   = USBIED_IDX_ZERO;
                        state_d = (mask_q == 4'h0) ? USBIED_ST_IDLE
                                                   : USBIED_ST_SEEK;   // [RULE18]
                    end
                end
            end
            USBIED_ST_SEEK: begin
                // Table read was launched by the slot address this cycle
                if (seek_hit[2]) begin
                    slot_d  = seek_hit[1:0];
                    state_d = USBIED_ST_WAIT;
                end else begin
                    state_d = USBIED_ST_IDLE;
                end
            end
            USBIED_ST_WAIT: begin
                ep_d    = rom_data;
                idx_d   = USBIED_IDX_ZERO;
                state_d = USBIED_ST_SEND;
            end
            USBIED_ST_SEND: begin
                if (adv) begin
                    valid_d = 1'b1;
                    data_d  = ep_byte;
                    last_d  = ep_end && !next_hit[2];
                    idx_d   = idx_q + USBIED_IDX_ONE;
                    if (ep_end) begin
                        idx_d   = USBIED_IDX_ZERO;
                        slot_d  = slot_next[1:0];
                        state_d = next_hit[2] ? USBIED_ST_SEEK
                                              : USBIED_ST_IDLE;        // [RULE12]
                    end
                end
            end
            default: begin
                state_d = USBIED_ST_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer state
    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            state_q <= USBIED_ST_IDLE;
            idx_q   <= USBIED_IDX_ZERO;
            slot_q  <= 2'b00;
            mask_q  <= 4'h0;
            cfg_q   <= '0;
            ep_q    <= '0;
        end else begin
            state_q <= state_d;
            idx_q   <= idx_d;
            slot_q  <= slot_d;
            mask_q  <= mask_d;
            cfg_q   <= cfg_d;
            ep_q    <= ep_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output byte stage
    // A single stage keeps the data registered at the cost of a bubble
    // between descriptors while the next table entry is fetched
    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            valid_q <= 1'b0;
            data_q  <= USBIED_ZERO_BYTE;
            last_q  <= 1'b0;
            stall_q <= 1'b0;
        end else begin
            valid_q <= valid_d;
            data_q  <= data_d;
            last_q  <= last_d;
            stall_q <= stall_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Segment length for the header's total length, from the live enables
    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            seg_len_q <= 16'h0000;
        end else begin
            seg_len_q <= 16'(USBIED_IF_LEN)
                       + 16'(16'(USBIED_EP_LEN) * 16'(usbied_count(EP_ENABLE)));
        end
    end

    assign TX_VALID  = valid_q;
    assign TX_DATA   = data_q;
    assign TX_LAST   = last_q;
    assign REQ_STALL = stall_q;
    assign SEG_LEN   = seg_len_q;
    assign SEG_BUSY  = (state_q != USBIED_ST_IDLE) || valid_q;

endmodule : usbied_top

// [dv/usbied_chk.sv]
/*
 * Concurrent checks on the descriptor streamer ports, bound into the top.
 * Assumes IF_CFG and EP_ENABLE stay steady while a segment streams.
 */
`timescale 1ns/1ps
module usbied_chk
    import usbied_pkg::*;
(
    input wire logic        MCLK,
    input wire logic        NRST,
    input wire logic        REQ_VALID,
    input usbied_req_t      REQ_KIND,
    input wire logic        REQ_READY,
    input wire logic        REQ_STALL,
    input usbied_if_cfg_t   IF_CFG,
    input wire logic [3:0]  EP_ENABLE,
    input wire logic [15:0] SEG_LEN,
    input wire logic        SEG_BUSY,
    input wire logic        TX_VALID,
    input wire logic [7:0]  TX_DATA,
    input wire logic        TX_LAST,
    input wire logic        TX_READY
);
    logic [7:0] idx_q;
    logic       up_q;
    // Request and byte handshakes
    wire        take_cfg = REQ_VALID && REQ_READY && (REQ_KIND == USBIED_REQ_CONFIG);
    wire        take_bad = REQ_VALID && REQ_READY && (REQ_KIND != USBIED_REQ_CONFIG);
    wire        tx_take  = TX_VALID && TX_READY;

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!NRST);

    // Byte position inside the segment, restarted by each accepted configuration request
    always_ff @(posedge MCLK) begin
        if (!NRST || take_cfg) begin
            idx_q <= 8'h00;
        end else if (tx_take) begin
            idx_q <= idx_q + 8'h01;
        end
    end

    // SEG_LEN lags reset release by one edge, so its check waits for this
    always_ff @(posedge MCLK) begin
        up_q <= NRST;
    end

    ////////////////////////////////////////////////////////////
    property p_refuse; take_bad |=> REQ_STALL && !TX_VALID; endproperty
    a_refuse: assert property (p_refuse) else $error("refused request not stalled");
    property p_stall_cause; REQ_STALL |-> $past(take_bad); endproperty
    a_stall_cause: assert property (p_stall_cause) else $error("stall without cause");
    // The byte register loads one edge after the take, so it is seen two edges on
    property p_first; take_cfg |-> ##2 (TX_VALID && (TX_DATA == 8'h09)); endproperty
    a_first: assert property (p_first) else $error("first byte not length nine");
    property p_type; TX_VALID && (idx_q == 8'h01) |-> TX_DATA == 8'h04; endproperty
    a_type: assert property (p_type) else $error("interface type byte wrong");
    property p_number; TX_VALID && (idx_q == 8'h02) |-> TX_DATA == IF_CFG.number; endproperty
    a_number: assert property (p_number) else $error("interface number byte wrong");
    property p_count;
        TX_VALID && (idx_q == 8'h04) |-> TX_DATA == 8'($countones(EP_ENABLE));
    endproperty
    a_count: assert property (p_count) else $error("endpoint count byte wrong");
    property p_sub;
        TX_VALID && (idx_q == 8'h06) && (IF_CFG.cls == 8'h00) |-> TX_DATA == 8'h00;
    endproperty
    a_sub: assert property (p_sub) else $error("subclass not zero for class zero");
    property p_hold;
        TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA) && $stable(TX_LAST);
    endproperty
    a_hold: assert property (p_hold) else $error("byte changed before taken");
    property p_seglen;
        up_q |-> SEG_LEN == 16'(9 + 7 * $countones($past(EP_ENABLE)));
    endproperty
    a_seglen: assert property (p_seglen) else $error("segment length wrong");
    property p_iflast;
        TX_VALID && (idx_q == 8'h08) |-> TX_LAST == (EP_ENABLE == 4'h0);
    endproperty
    a_iflast: assert property (p_iflast) else $error("last marker wrong on byte nine");
    property p_ep_follow;
        tx_take && (idx_q == 8'h08) && (EP_ENABLE != 4'h0) |->
            ##[1:3] (TX_VALID && (TX_DATA == 8'h07));
    endproperty
    a_ep_follow: assert property (p_ep_follow) else $error("endpoint did not follow");
    property p_end; tx_take && TX_LAST |=> !TX_VALID && REQ_READY && !SEG_BUSY; endproperty
    a_end: assert property (p_end) else $error("segment did not close");

    // Main scenarios
    c_stall: cover property (take_bad ##1 take_bad);
    c_full: cover property (tx_take && TX_LAST && (EP_ENABLE == 4'hF));
    c_wait: cover property (TX_VALID && !TX_READY);
endmodule : usbied_chk

bind usbied_top usbied_chk u_chk (
    .MCLK(MCLK), .NRST(NRST), .REQ_VALID(REQ_VALID), .REQ_KIND(REQ_KIND),
    .REQ_READY(REQ_READY), .REQ_STALL(REQ_STALL), .IF_CFG(IF_CFG),
    .EP_ENABLE(EP_ENABLE), .SEG_LEN(SEG_LEN), .SEG_BUSY(SEG_BUSY), .TX_VALID(TX_VALID),
    .TX_DATA(TX_DATA), .TX_LAST(TX_LAST), .TX_READY(TX_READY)
);

// [dv/usbied_host_model.sv]
/*
 * Host side byte sink: gathers the streamed descriptor bytes in order.
 * Assumes the bench clears rx_q and done before each request.
 */
`timescale 1ns/1ps
module usbied_host_model (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       slow,
    input wire logic       tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic       tx_last,
    output logic           tx_ready
);
    logic [7:0] rx_q [$];
    logic       done;

    initial begin
        tx_ready = 1'b1;
        done = 1'b0;
    end

    // Take bytes in arrival order; slow mode alternates ready to force stalls
    always @(posedge clk) begin
        if (rst_n && tx_valid && tx_ready) begin
            rx_q.push_back(tx_data);
            if (tx_last) begin
                done = 1'b1;
            end
        end
        #1 tx_ready = slow ? ~tx_ready : 1'b1;
    end
endmodule : usbied_host_model

// [dv/usbied_top_bench.sv]
/*
 * Self-checking bench for the descriptor streamer with a host sink model.
 * Assumes the checker is bound into the top by its own file.
 */
`timescale 1ns/1ps
module usbied_top_bench
    import usbied_pkg::*;
;
    logic mclk, nrst, req_valid, req_ready, req_stall, seg_busy, slow;
    logic tx_valid, tx_last, tx_ready;
    logic [7:0] tx_data;
    logic [3:0] ep_enable;
    logic [15:0] seg_len;
    usbied_req_t req_kind;
    usbied_if_cfg_t if_cfg;
    int miscompares = 0;
    int checked = 0;
    localparam logic [55:0] ep_rows [4] = '{56'h07058102100000, 56'h07050102100000,
                                            56'h07058203080064, 56'h07050202080000};

    usbied_top uut (.MCLK(mclk), .NRST(nrst), .REQ_VALID(req_valid), .REQ_KIND(req_kind),
        .REQ_READY(req_ready), .REQ_STALL(req_stall), .IF_CFG(if_cfg), .EP_ENABLE(ep_enable),
        .SEG_LEN(seg_len), .SEG_BUSY(seg_busy), .TX_VALID(tx_valid), .TX_DATA(tx_data),
        .TX_LAST(tx_last), .TX_READY(tx_ready));
    usbied_host_model hm (.clk(mclk), .rst_n(nrst), .slow(slow), .tx_valid(tx_valid),
        .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready));

    // Clock at 125 MHz
    always #4 mclk = ~mclk;

    ////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic end_sim;
        $display("checks %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_sim

    // Refused kinds back to back: each stalls, nothing streams
    task automatic t_refuse;
        for (int k = 1; k < 4; k++) begin
            req_valid = 1'b1;
            req_kind = usbied_req_t'(k);
            @(posedge mclk);
            #1;
            check(16'(req_stall), 16'h0001);
            check(16'(tx_valid), 16'h0000);
        end
        req_valid = 1'b0;
        @(posedge mclk);
        #1;
        check(16'(req_stall), 16'h0000);
    endtask : t_refuse

    // One configuration segment, judged byte by byte against the expected layout
    task automatic t_segment(input usbied_if_cfg_t cfg, input logic [3:0] mask,
                             input logic slw);
        logic [7:0] exp_q [$];
        int n;
        exp_q = '{8'h09, 8'h04, cfg.number, cfg.alt, 8'($countones(mask)), cfg.cls,
                  (cfg.cls == 8'h00) ? 8'h00 : cfg.sub, cfg.proto, cfg.str_idx};
        for (int i = 0; i < 4; i++) begin
            for (int b = 0; b < 7; b++) begin
                if (mask[i]) begin
                    exp_q.push_back(ep_rows[i][55 - 8 * b -: 8]);
                end
            end
        end
        if_cfg = cfg;
        ep_enable = mask;
        slow = slw;
        hm.rx_q.delete();
        hm.done = 1'b0;
        repeat (2) @(posedge mclk);
        #1;
        check(seg_len, 16'(9 + 7 * $countones(mask)));
        req_valid = 1'b1;
        req_kind = USBIED_REQ_CONFIG;
        @(posedge mclk);
        #1 req_valid = 1'b0;
        for (n = 0; n < 300 && hm.done !== 1'b1; n++) begin
            @(posedge mclk);
        end
        @(posedge mclk);
        #1;
        check(16'(hm.done), 16'h0001);
        check(16'({seg_busy, req_ready}), 16'h0001);
        check(16'(hm.rx_q.size()), 16'(exp_q.size()));
        for (int i = 0; i < exp_q.size() && i < hm.rx_q.size(); i++) begin
            check(16'(hm.rx_q[i]), 16'(exp_q[i]));
        end
    endtask : t_segment

    ////////////////////////////////////////////////////////////
    // Hang guard reckoned at about a hundred times the expected run
    initial begin
        #200000;
        miscompares++;
        end_sim();
    end

    // Main sequence
    initial begin
        mclk = 1'b0;
        nrst = 1'b0;
        req_valid = 1'b0;
        req_kind = USBIED_REQ_CONFIG;
        if_cfg = '0;
        ep_enable = 4'hF;
        slow = 1'b0;
        repeat (20) @(posedge mclk);
        #1;
        check(16'({tx_valid, req_stall, seg_busy, req_ready}), 16'h0001);
        nrst = 1'b1;
        t_refuse();
        t_segment('0, 4'hF, 1'b0);
        t_segment('{8'h01, 8'h02, 8'hFF, 8'h12, 8'hFF, 8'h05}, 4'h5, 1'b1);
        t_segment('{8'h00, 8'h00, 8'h00, 8'h34, 8'h00, 8'h00}, 4'h0, 1'b0);
        t_segment('{8'h00, 8'h01, 8'h3C, 8'h00, 8'h07, 8'h00}, 4'hA, 1'b1);
        t_refuse();
        end_sim();
    end
endmodule : usbied_top_bench
